/* File: verilog/gpd_pkg.sv */
package gpd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register byte offsets on the plain register port
    localparam logic [7:0] OFS_PORT_A_DIR = 8'h02;
    localparam logic [7:0] OFS_PORT_C_DATA = 8'h04;
    localparam logic [7:0] OFS_PORT_D_DATA = 8'h05;
    localparam logic [7:0] OFS_PORT_C_DIR = 8'h06;
    localparam logic [7:0] OFS_PORT_D_DIR = 8'h07;
    localparam logic [7:0] OFS_PORT_E_DIR = 8'h09;
    localparam logic [7:0] OFS_ALT_CTRL = 8'h0A;

    // Reset values
    localparam logic [7:0] RST_PORT_A_DIR = 8'h00;
    localparam logic [7:0] RST_PORT_E_DIR = 8'h00;
    localparam logic [1:0] RST_PORT_C = 2'h0;
    localparam logic [7:0] RST_PORT_D = 8'h00;
    localparam logic [3:0] RST_ALT_CTRL = 4'h0;

    // Implemented widths
    localparam int PORT_C_BITS = 2;
    localparam int PORT_E_BITS = 2;
    localparam int SPI_PINS = 4;
    localparam int LINK_NARROW = 4;

    // Alternate-function control field positions
    localparam int ALT_SPI_EN = 0;
    localparam int ALT_OSC_EN = 1;
    localparam int ALT_LINK_EN = 2;
    localparam int ALT_LINK_WIDE = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gpd_req_type;

    // Drive bundle for one 8-bit port
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
    } gpd_drive_type;

endpackage

/* File: verilog/gpd_sync.sv */
module gpd_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [WIDTH-1:0] din, // Asynchronous pin levels
    output logic [WIDTH-1:0] dout // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= '0;
            dout <= '0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule // gpd_sync

/* File: verilog/gpd_port.sv */
// Overview of operation
// - Port A direction: 8-bit read/write, resets zero, 1 output, 0 input.
// - SPI enabled forces pins A3..A0 direction; stored direction bits unchanged.
// - Oscillator enabled hands pins E1..E0 to oscillator; stored bits unchanged.
// - Port E general purpose pins: direction 1 output, 0 input.
// - Port C data holds bits 1..0 only; upper bits read zero; reset zero.
// - Link active: C1 carries link interrupt, C0 carries link clock.
// - Port C/D pins not claimed by the link act as general purpose I/O.
// - Data read returns register if direction 1, else synchronised pin.
// - Link in 8-bit mode: D7..D0 carry link data.
// - Link in 4-bit mode: only D3..D0 link data; D7..D4 stay general.
// - Port D data: full 8-bit read/write register, resets zero.
// - Port C/D general purpose output pins drive the stored data bit; port A and E ones drive low.
// - Link active controls direction of C1..C0 and of the D pins it claims; stored direction bits unchanged.
module gpd_port (
    input wire logic mclk, // System clock, 125 MHz
    input wire logic reset_n, // Async reset, active low
    input wire gpd_pkg::gpd_req_type req, // Register request
    output logic [7:0] rdata, // Read data, cycle after read strobe
    input wire logic [7:0] pa_in, // Port A pin levels
    output gpd_pkg::gpd_drive_type pa_drv, // Port A drive and enable
    input wire logic [1:0] pe_in, // Port E pin levels
    output logic [1:0] pe_dout, // Port E drive levels
    output logic [1:0] pe_oe, // Port E output enables
    input wire logic [1:0] pc_in, // Port C pin levels
    output logic [1:0] pc_dout, // Port C drive levels
    output logic [1:0] pc_oe, // Port C output enables
    input wire logic [7:0] pd_in, // Port D pin levels
    output gpd_pkg::gpd_drive_type pd_drv, // Port D drive and enable
    input wire logic [3:0] spi_oe, // SPI wanted enables for A3..A0
    input wire logic [3:0] spi_dout, // SPI drive levels for A3..A0
    output logic spi_en, // SPI function enabled
    output logic osc_en, // Oscillator owns E1..E0
    output logic link_en, // Link owns its pins
    output logic link_wide, // Link uses 8-bit data
    input wire logic link_int_oe, // Link enable for interrupt pin
    input wire logic link_int_out, // Link interrupt drive
    input wire logic link_clk_oe, // Link enable for clock pin
    input wire logic link_clk_out, // Link clock drive
    input wire logic [7:0] link_dat_oe, // Link data enables
    input wire logic [7:0] link_dat_out, // Link data drive
    output logic [1:0] link_c_in, // Synchronised C pins to link
    output logic [7:0] link_d_in // Synchronised D pins to link
);

    logic [7:0] pa_dir_q;
    logic [1:0] pe_dir_q;
    logic [1:0] pc_dir_q;
    logic [7:0] pd_dir_q;
    logic [1:0] pc_dat_q;
    logic [7:0] pd_dat_q;
    logic [3:0] alt_q;
    logic [7:0] rdata_d;
    logic [7:0] pa_s;
    logic [1:0] pe_s;
    logic [1:0] pc_s;
    logic [7:0] pd_s;
    logic [7:0] d_claim;
    logic [7:0] pa_oe_d;
    logic [7:0] pa_do_d;
    logic [1:0] pe_oe_d;
    logic [1:0] pc_oe_d;
    logic [1:0] pc_do_d;
    logic [7:0] pd_oe_d;
    logic [7:0] pd_do_d;
    logic [19:0] sync_raw;
    logic [19:0] sync_out;

    // All pin inputs share one synchroniser
    assign sync_raw = {pa_in, pe_in, pc_in, pd_in};

    gpd_sync #(
        .WIDTH(20)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .din(sync_raw),
        .dout(sync_out)
    );

    assign pa_s = sync_out[19:12];
    assign pe_s = sync_out[11:10];
    assign pc_s = sync_out[9:8];
    assign pd_s = sync_out[7:0];

    // Register writes
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pa_dir_q <= gpd_pkg::RST_PORT_A_DIR;
            pe_dir_q <= gpd_pkg::RST_PORT_E_DIR[1:0];
            pc_dir_q <= gpd_pkg::RST_PORT_C;
            pd_dir_q <= gpd_pkg::RST_PORT_D;
            pc_dat_q <= gpd_pkg::RST_PORT_C;
            pd_dat_q <= gpd_pkg::RST_PORT_D;
            alt_q <= gpd_pkg::RST_ALT_CTRL;
        end
        else if (req.wr)
        begin
            case (req.addr)
                gpd_pkg::OFS_PORT_A_DIR: pa_dir_q <= req.wdata;
                gpd_pkg::OFS_PORT_E_DIR: pe_dir_q <= req.wdata[1:0];
                gpd_pkg::OFS_PORT_C_DATA: pc_dat_q <= req.wdata[1:0];
                gpd_pkg::OFS_PORT_D_DATA: pd_dat_q <= req.wdata;
                gpd_pkg::OFS_PORT_C_DIR: pc_dir_q <= req.wdata[1:0];
                gpd_pkg::OFS_PORT_D_DIR: pd_dir_q <= req.wdata;
                gpd_pkg::OFS_ALT_CTRL: alt_q <= req.wdata[3:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_d = 8'h00;
        case (req.addr)
            gpd_pkg::OFS_PORT_A_DIR: rdata_d = pa_dir_q;
            gpd_pkg::OFS_PORT_E_DIR: rdata_d = {6'h00, pe_dir_q};
            gpd_pkg::OFS_PORT_C_DATA:
                rdata_d = {6'h00, (pc_dir_q & pc_dat_q) | (~pc_dir_q & pc_s)};
            gpd_pkg::OFS_PORT_D_DATA:
                rdata_d = (pd_dir_q & pd_dat_q) | (~pd_dir_q & pd_s);
            gpd_pkg::OFS_PORT_C_DIR: rdata_d = {6'h00, pc_dir_q};
            gpd_pkg::OFS_PORT_D_DIR: rdata_d = pd_dir_q;
            gpd_pkg::OFS_ALT_CTRL: rdata_d = {4'h0, alt_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= req.rd ? rdata_d : 8'h00;
        end
    end

    // Link data claim: all eight pins wide, low four narrow
    assign d_claim = !alt_q[gpd_pkg::ALT_LINK_EN] ? 8'h00 :
                     (alt_q[gpd_pkg::ALT_LINK_WIDE] ? 8'hFF : 8'h0F);

    // Pin muxing; the stored direction bits are never touched here
    always_comb
    begin
        pa_oe_d = pa_dir_q;
        pa_do_d = 8'h00;
        pe_oe_d = pe_dir_q;
        pc_oe_d = pc_dir_q;
        pc_do_d = pc_dat_q;
        pd_oe_d = pd_dir_q;
        pd_do_d = pd_dat_q;
        // Port A data register lives elsewhere; GP outputs drive low here
        if (alt_q[gpd_pkg::ALT_SPI_EN])
        begin
            pa_oe_d[3:0] = spi_oe;
            pa_do_d[3:0] = spi_dout;
        end
        // Oscillator is analog; digital drivers stay off
        if (alt_q[gpd_pkg::ALT_OSC_EN])
        begin
            pe_oe_d = 2'h0;
        end
        if (alt_q[gpd_pkg::ALT_LINK_EN])
        begin
            pc_oe_d = {link_int_oe, link_clk_oe};
            pc_do_d = {link_int_out, link_clk_out};
        end
        for (int i = 0; i < 8; i++)
        begin
            if (d_claim[i])
            begin
                pd_oe_d[i] = link_dat_oe[i];
                pd_do_d[i] = link_dat_out[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pa_drv <= '0;
            pe_dout <= 2'h0;
            pe_oe <= 2'h0;
            pc_dout <= 2'h0;
            pc_oe <= 2'h0;
            pd_drv <= '0;
            spi_en <= 1'b0;
            osc_en <= 1'b0;
            link_en <= 1'b0;
            link_wide <= 1'b0;
            link_c_in <= 2'h0;
            link_d_in <= 8'h00;
        end
        else
        begin
            pa_drv.oe <= pa_oe_d;
            pa_drv.dout <= pa_do_d;
            pe_oe <= pe_oe_d;
            pe_dout <= 2'h0;
            pc_oe <= pc_oe_d;
            pc_dout <= pc_do_d;
            pd_drv.oe <= pd_oe_d;
            pd_drv.dout <= pd_do_d;
            spi_en <= alt_q[gpd_pkg::ALT_SPI_EN];
            osc_en <= alt_q[gpd_pkg::ALT_OSC_EN];
            link_en <= alt_q[gpd_pkg::ALT_LINK_EN];
            link_wide <= alt_q[gpd_pkg::ALT_LINK_WIDE];
            link_c_in <= pc_s;
            link_d_in <= pd_s;
        end
    end

    property p_read_c_upper;
        @(posedge mclk) disable iff (!reset_n)
        $past(req.rd) |-> rdata[7:2] == 6'h00 || $past(req.addr) != gpd_pkg::OFS_PORT_C_DATA;
    endproperty
    a_read_c_upper: assert property (p_read_c_upper) else $error("port C high bits nonzero");

    property p_dir_a_write;
        @(posedge mclk) disable iff (!reset_n)
        req.wr && req.addr == gpd_pkg::OFS_PORT_A_DIR |=> pa_dir_q == $past(req.wdata);
    endproperty
    a_dir_a_write: assert property (p_dir_a_write) else $error("port A direction not stored");

    property p_spi_force;
        @(posedge mclk) disable iff (!reset_n)
        alt_q[gpd_pkg::ALT_SPI_EN] |=> pa_drv.oe[3:0] == $past(spi_oe);
    endproperty
    a_spi_force: assert property (p_spi_force) else $error("SPI direction not forced");

    property p_osc_off;
        @(posedge mclk) disable iff (!reset_n)
        alt_q[gpd_pkg::ALT_OSC_EN] |=> pe_oe == 2'h0;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("port E driven under oscillator");

    property p_pe_gp;
        @(posedge mclk) disable iff (!reset_n)
        !alt_q[gpd_pkg::ALT_OSC_EN] |=> pe_oe == $past(pe_dir_q);
    endproperty
    a_pe_gp: assert property (p_pe_gp) else $error("port E direction wrong");

    property p_link_clk;
        @(posedge mclk) disable iff (!reset_n)
        alt_q[gpd_pkg::ALT_LINK_EN] |=> pc_dout[0] == $past(link_clk_out);
    endproperty
    a_link_clk: assert property (p_link_clk) else $error("link clock not on C0");

    property p_narrow_gp;
        @(posedge mclk) disable iff (!reset_n)
        !alt_q[gpd_pkg::ALT_LINK_WIDE] |=> pd_drv.dout[7:4] == $past(pd_dat_q[7:4]);
    endproperty
    a_narrow_gp: assert property (p_narrow_gp) else $error("upper port D lost");

    property p_wide_link;
        @(posedge mclk) disable iff (!reset_n)
        alt_q[gpd_pkg::ALT_LINK_EN] && alt_q[gpd_pkg::ALT_LINK_WIDE]
            |=> pd_drv.oe == $past(link_dat_oe);
    endproperty
    a_wide_link: assert property (p_wide_link) else $error("link data not on port D");

    // Skip reads whose synchroniser still showed its reset value
    sequence s_pin_rd;
        $past(reset_n, 2) && req.rd && req.addr == gpd_pkg::OFS_PORT_D_DATA
            && pd_dir_q == 8'h00;
    endsequence

    property p_sync_read;
        @(posedge mclk) disable iff (!reset_n)
        s_pin_rd |=> rdata == $past(pd_in, 3);
    endproperty
    a_sync_read: assert property (p_sync_read) else $error("pin read not synchronised");

    sequence s_reg_rd;
        req.rd && req.addr == gpd_pkg::OFS_PORT_D_DATA && pd_dir_q == 8'hFF;
    endsequence

    property p_read_d_reg;
        @(posedge mclk) disable iff (!reset_n)
        s_reg_rd |=> rdata == $past(pd_dat_q);
    endproperty
    a_read_d_reg: assert property (p_read_d_reg) else $error("D read wrong");

    // Synchroniser flops leave reset at zero, so the first edges after release are skipped
    property p_sync_ae;
        @(posedge mclk) disable iff (!reset_n)
        $past(reset_n, 2) |-> pa_s == $past(pa_in, 2) && pe_s == $past(pe_in, 2);
    endproperty
    a_sync_ae: assert property (p_sync_ae) else $error("A/E sync wrong");

    property p_sync_cd;
        @(posedge mclk) disable iff (!reset_n)
        $past(reset_n, 2) |-> pc_s == $past(pc_in, 2) && pd_s == $past(pd_in, 2);
    endproperty
    a_sync_cd: assert property (p_sync_cd) else $error("C/D sync wrong");

    property p_link_in;
        @(posedge mclk) disable iff (!reset_n)
        $past(reset_n, 3) |-> link_c_in == $past(pc_in, 3) && link_d_in == $past(pd_in, 3);
    endproperty
    a_link_in: assert property (p_link_in) else $error("link pin copy wrong");

    property p_link_int;
        @(posedge mclk) disable iff (!reset_n)
        alt_q[gpd_pkg::ALT_LINK_EN]
            |=> pc_dout[1] == $past(link_int_out) && pc_oe[1] == $past(link_int_oe)
                && pc_oe[0] == $past(link_clk_oe);
    endproperty
    a_link_int: assert property (p_link_int) else $error("link C pins lost");

    // Alternate functions override the pins only; stored directions move on writes alone
    property p_dir_a_kept;
        @(posedge mclk) disable iff (!reset_n)
        !(req.wr && req.addr == gpd_pkg::OFS_PORT_A_DIR) |=> $stable(pa_dir_q);
    endproperty
    a_dir_a_kept: assert property (p_dir_a_kept) else $error("A direction changed");

    property p_dir_e_kept;
        @(posedge mclk) disable iff (!reset_n)
        !(req.wr && req.addr == gpd_pkg::OFS_PORT_E_DIR) |=> $stable(pe_dir_q);
    endproperty
    a_dir_e_kept: assert property (p_dir_e_kept) else $error("E direction changed");

    property p_dir_c_kept;
        @(posedge mclk) disable iff (!reset_n)
        !(req.wr && req.addr == gpd_pkg::OFS_PORT_C_DIR) |=> $stable(pc_dir_q);
    endproperty
    a_dir_c_kept: assert property (p_dir_c_kept) else $error("C direction changed");

    property p_dir_d_kept;
        @(posedge mclk) disable iff (!reset_n)
        !(req.wr && req.addr == gpd_pkg::OFS_PORT_D_DIR) |=> $stable(pd_dir_q);
    endproperty
    a_dir_d_kept: assert property (p_dir_d_kept) else $error("D direction changed");

    property p_gp_d_out;
        @(posedge mclk) disable iff (!reset_n)
        !alt_q[gpd_pkg::ALT_LINK_EN]
            |=> pd_drv.oe == $past(pd_dir_q) && pd_drv.dout == $past(pd_dat_q);
    endproperty
    a_gp_d_out: assert property (p_gp_d_out) else $error("port D GP drive wrong");

    property p_gp_c_out;
        @(posedge mclk) disable iff (!reset_n)
        !alt_q[gpd_pkg::ALT_LINK_EN]
            |=> pc_oe == $past(pc_dir_q) && pc_dout == $past(pc_dat_q);
    endproperty
    a_gp_c_out: assert property (p_gp_c_out) else $error("port C GP drive wrong");

endmodule // gpd_port

/* File: tb/gpd_pin_model.sv */
module gpd_pin_model (
    input wire gpd_pkg::gpd_drive_type pa_drv, // Port A drive from the block
    input wire gpd_pkg::gpd_drive_type pd_drv, // Port D drive from the block
    input wire logic [1:0] pc_dout, // Port C drive levels
    input wire logic [1:0] pc_oe, // Port C enables
    input wire logic [1:0] pe_dout, // Port E drive levels
    input wire logic [1:0] pe_oe, // Port E enables
    input wire logic [7:0] ext_a, // Board level on port A
    input wire logic [1:0] ext_c, // Board level on port C
    input wire logic [7:0] ext_d, // Board level on port D
    input wire logic [1:0] ext_e, // Board level on port E
    output logic [7:0] pa_in, // Resolved port A pins
    output logic [1:0] pc_in, // Resolved port C pins
    output logic [7:0] pd_in, // Resolved port D pins
    output logic [1:0] pe_in // Resolved port E pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // A driven pin shows the block's level, an undriven one the board's
    assign pa_in = (pa_drv.oe & pa_drv.dout) | (~pa_drv.oe & ext_a);
    assign pc_in = (pc_oe & pc_dout) | (~pc_oe & ext_c);
    assign pd_in = (pd_drv.oe & pd_drv.dout) | (~pd_drv.oe & ext_d);
    assign pe_in = (pe_oe & pe_dout) | (~pe_oe & ext_e);
endmodule // gpd_pin_model

/* File: tb/gpd_port_tb.sv */
module gpd_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, reset_n, spi_en, osc_en, link_en, link_wide;
    logic link_int_oe, link_int_out, link_clk_oe, link_clk_out;
    gpd_pkg::gpd_req_type req;
    gpd_pkg::gpd_drive_type pa_drv, pd_drv;
    logic [7:0] rdata, pa_in, pd_in, ext_a, ext_d, link_dat_oe, link_dat_out, link_d_in;
    logic [3:0] spi_oe, spi_dout;
    logic [1:0] pe_in, pe_dout, pe_oe, pc_in, pc_dout, pc_oe, ext_c, ext_e, link_c_in;
    logic [7:0] ofs [6];
    int failures, checks, cycles;

    gpd_port dut (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata),
        .pa_in(pa_in), .pa_drv(pa_drv), .pe_in(pe_in), .pe_dout(pe_dout), .pe_oe(pe_oe),
        .pc_in(pc_in), .pc_dout(pc_dout), .pc_oe(pc_oe), .pd_in(pd_in), .pd_drv(pd_drv),
        .spi_oe(spi_oe), .spi_dout(spi_dout), .spi_en(spi_en), .osc_en(osc_en),
        .link_en(link_en), .link_wide(link_wide), .link_int_oe(link_int_oe),
        .link_int_out(link_int_out), .link_clk_oe(link_clk_oe), .link_clk_out(link_clk_out),
        .link_dat_oe(link_dat_oe), .link_dat_out(link_dat_out), .link_c_in(link_c_in),
        .link_d_in(link_d_in));

    gpd_pin_model pins (.pa_drv(pa_drv), .pd_drv(pd_drv), .pc_dout(pc_dout), .pc_oe(pc_oe),
        .pe_dout(pe_dout), .pe_oe(pe_oe), .ext_a(ext_a), .ext_c(ext_c), .ext_d(ext_d),
        .ext_e(ext_e), .pa_in(pa_in), .pc_in(pc_in), .pd_in(pd_in), .pe_in(pe_in));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // Pin outputs trail register state, and pin inputs pass a synchroniser
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            complete_run();
        end
    end

    initial
    begin
        req = '0;
        reset_n = 1'b0;
        {ext_a, ext_d, ext_c, ext_e} = '0;
        {spi_oe, spi_dout, link_dat_oe, link_dat_out} = '0;
        {link_int_oe, link_int_out, link_clk_oe, link_clk_out} = '0;
        failures = 0;
        checks = 0;
        cycles = 0;
        ofs = '{gpd_pkg::OFS_PORT_A_DIR, gpd_pkg::OFS_PORT_C_DATA, gpd_pkg::OFS_PORT_D_DATA,
            gpd_pkg::OFS_PORT_C_DIR, gpd_pkg::OFS_PORT_D_DIR, gpd_pkg::OFS_PORT_E_DIR};
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        wr(gpd_pkg::OFS_PORT_A_DIR, 8'hA5);
        rd(gpd_pkg::OFS_PORT_A_DIR, 8'hA5);
        rd(8'h03, 8'h00);
        settle();
        chk(pa_drv.oe, 8'hA5);
        ext_c <= 2'h2;
        wr(gpd_pkg::OFS_PORT_C_DATA, 8'hFF);
        settle();
        rd(gpd_pkg::OFS_PORT_C_DATA, 8'h02);
        chk({6'h00, link_c_in}, 8'h02);
        wr(gpd_pkg::OFS_PORT_C_DIR, 8'h03);
        rd(gpd_pkg::OFS_PORT_C_DATA, 8'h03);
        settle();
        chk({4'h0, pc_oe, pc_dout}, 8'h0F);
        wr(gpd_pkg::OFS_PORT_D_DIR, 8'hFF);
        wr(gpd_pkg::OFS_PORT_D_DATA, 8'h5A);
        rd(gpd_pkg::OFS_PORT_D_DATA, 8'h5A);
        settle();
        chk(pd_drv.dout, 8'h5A);
        ext_d <= 8'hC3;
        wr(gpd_pkg::OFS_PORT_D_DIR, 8'h00);
        settle();
        rd(gpd_pkg::OFS_PORT_D_DATA, 8'hC3);
        chk(link_d_in, 8'hC3);
        wr(gpd_pkg::OFS_PORT_E_DIR, 8'h03);
        settle();
        chk({6'h00, pe_oe}, 8'h03);
        chk({6'h00, pe_dout}, 8'h00);
        wr(gpd_pkg::OFS_ALT_CTRL, 8'h02);
        settle();
        chk({6'h00, pe_oe}, 8'h00);
        chk({7'h00, osc_en}, 8'h01);
        rd(gpd_pkg::OFS_PORT_E_DIR, 8'h03);
        wr(gpd_pkg::OFS_PORT_A_DIR, 8'hF0);
        spi_oe <= 4'h5;
        spi_dout <= 4'hF;
        wr(gpd_pkg::OFS_ALT_CTRL, 8'h01);
        settle();
        chk(pa_drv.oe, 8'hF5);
        chk({7'h00, spi_en}, 8'h01);
        chk(pa_drv.dout, 8'h0F);
        rd(gpd_pkg::OFS_PORT_A_DIR, 8'hF0);
        wr(gpd_pkg::OFS_PORT_D_DIR, 8'hF0);
        link_dat_oe <= 8'h0C;
        link_dat_out <= 8'h09;
        link_int_oe <= 1'b1;
        link_int_out <= 1'b1;
        wr(gpd_pkg::OFS_PORT_D_DATA, 8'h5A);
        wr(gpd_pkg::OFS_ALT_CTRL, 8'h04);
        settle();
        chk(pd_drv.oe, 8'hFC);
        chk(pd_drv.dout, 8'h59);
        chk({4'h0, pc_oe, pc_dout}, 8'h0A);
        chk({6'h00, link_en, link_wide}, 8'h02);
        chk(pa_drv.oe, 8'hF0);
        rd(gpd_pkg::OFS_PORT_C_DIR, 8'h03);
        wr(gpd_pkg::OFS_ALT_CTRL, 8'h0C);
        settle();
        chk(pd_drv.oe, 8'h0C);
        chk(pd_drv.dout, 8'h09);
        chk({6'h00, link_en, link_wide}, 8'h03);
        rd(gpd_pkg::OFS_PORT_D_DIR, 8'hF0);
        rd(gpd_pkg::OFS_ALT_CTRL, 8'h0C);
        // Second reset in mid-run: every written register must fall back to zero
        @(posedge mclk);
        ext_c <= 2'h0;
        ext_d <= 8'h00;
        reset_n <= 1'b0;
        settle();
        chk(pa_drv.oe, 8'h00);
        chk(pd_drv.oe, 8'h00);
        chk({6'h00, link_en, link_wide}, 8'h00);
        @(posedge mclk);
        reset_n <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        rd(gpd_pkg::OFS_ALT_CTRL, 8'h00);
        complete_run();
    end
endmodule // gpd_port_tb
